// File: ret_consts.svh
`ifndef RET_CONSTS_SVH
`define RET_CONSTS_SVH

// ==========================================================================
// Register offsets (byte addresses, one 32-bit word each).
`define RET_OFF_CTRL     8'h00
`define RET_OFF_TICKDIV  8'h04
`define RET_OFF_COUNT    8'h08
`define RET_OFF_CMP0     8'h0C
`define RET_OFF_CMP1     8'h10
`define RET_OFF_CMP2     8'h14
`define RET_OFF_CMP3     8'h18
`define RET_OFF_CMPLOW   8'h1C
`define RET_OFF_STATUS   8'h20
`define RET_OFF_MASK     8'h24

// ==========================================================================
// Widths and field positions.
`define RET_CNT_W        24
`define RET_LOW_W        16
`define RET_DIV_W        16
`define RET_NFULL        4
`define RET_NEVT         5
`define RET_BIT_LOW      4

// ==========================================================================
// Reset values.
`define RET_CTRL_RST     5'h00
`define RET_MASK_RST     5'h00
`define RET_CMP_RST      24'h000000

// ==========================================================================
// Timing: system clock and default tick rate in Hz; divider counts cycles.
`define RET_MCLK_HZ      40000000
`define RET_TICK_HZ      250000
`define RET_TICK_DIV_RST ((`RET_MCLK_HZ / `RET_TICK_HZ) - 1)

`endif

// File: ret_pkg.sv
`include "ret_consts.svh"

package ret_pkg;

   typedef logic [7:0]               ret_addr_t;
   typedef logic [31:0]              ret_word_t;
   typedef logic [`RET_CNT_W-1:0]    ret_cnt_t;
   typedef logic [`RET_NEVT-1:0]     ret_evt_t;
   typedef logic [`RET_DIV_W-1:0]    ret_div_t;

   // Whole state of the timer top.
   typedef struct packed {
      ret_cnt_t                          count;
      logic                              upd;
      logic [`RET_NFULL-1:0][`RET_CNT_W-1:0] cmp;
      logic [`RET_LOW_W-1:0]             cmp_low;
      ret_evt_t                          cmp_en;
      ret_div_t                          tick_div;
      ret_evt_t                          status;
      ret_evt_t                          mask;
      ret_evt_t                          match;
      ret_word_t                         rdata;
   } ret_state_t;

   // State of the tick divider.
   typedef struct packed {
      ret_div_t cnt;
   } ret_div_state_t;

endpackage

// File: ret_time_if.sv
interface ret_time_if;
   import ret_pkg::*;

   ret_cnt_t count;
   logic     upd;

   modport drv (output count, output upd);
   modport cmp (input count, input upd);
endinterface

// File: ret_tick_gen.sv
`include "ret_consts.svh"

module ret_tick_gen
  #(parameter int DIV_W = `RET_DIV_W)
(
   // Clock and reset.
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   // Divider setting: ticks every div_i + 1 clocks.
   input  wire logic [DIV_W-1:0] div_i,
   // Tick pulse.
   output logic                  tick_o
);
   import ret_pkg::*;

   logic [DIV_W-1:0] cnt;
   logic [DIV_W-1:0] next_cnt;

   // ======================================================================
   // Divider. The compare uses >= so a shrunk setting never misses a wrap.
   always_comb
   begin
      tick_o   = (cnt >= div_i);
      next_cnt = tick_o ? '0 : cnt + 1'b1;
   end

   always_ff @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
         cnt <= '0;
      else
         cnt <= next_cnt;
   end
endmodule

// File: ret_comparator.sv
`include "ret_consts.svh"

module ret_comparator
  #(parameter int W = `RET_CNT_W)
(
   // Counter view.
   ret_time_if.cmp         tif,
   // Compare setting.
   input  wire logic [W-1:0] value_i,
   input  wire logic         enable_i,
   // Match pulse, one cycle per new counter value.
   output logic              match_o
);
   import ret_pkg::*;

   // ======================================================================
   // Only the low W counter bits take part; a disabled compare never fires.
   always_comb
   begin
      match_o = tif.upd & enable_i & (tif.count[W-1:0] == value_i);
   end
endmodule

// File: ret_timer.sv
// Function
// - One free-running counter with four independent 24-bit compare values.
// - Counter advances at 250 kHz by default; tick divider is software selectable.
// - A compare value equal to the counter sets that comparator's status flag when its compare enable is set.
// - Each status flag has its own interrupt enable driving the interrupt request.
// - An extra 16-bit comparator checks only the low 16 counter bits.
// - With its compare enable at one, a match sets the status flag.
// - With its compare enable at zero, a match never sets the status flag.
// - Counter value and match pulses are offered to the sequencer too.
`include "ret_consts.svh"

module ret_timer
(
   // Clock and reset.
   input  wire logic               MCLK_I,
   input  wire logic               RST_I,
   // Register port.
   input  wire ret_pkg::ret_addr_t ADDR_I,
   input  wire ret_pkg::ret_word_t WDATA_I,
   input  wire logic               WR_I,
   input  wire logic               RD_I,
   output      ret_pkg::ret_word_t RDATA_O,
   // Interrupt request.
   output      logic               IRQ_O,
   // Sequencer side.
   output      ret_pkg::ret_cnt_t  SEQ_COUNT_O,
   output      ret_pkg::ret_evt_t  SEQ_MATCH_O,
   output      logic               SEQ_TICK_O
);
   import ret_pkg::*;

   // ======================================================================
   // Reset image of the whole state.
   localparam ret_div_t   TICK_DIV_RST = ret_div_t'(`RET_TICK_DIV_RST);
   localparam ret_state_t RST_ST = '{
      count    : '0,
      upd      : 1'b0,
      cmp      : '0,
      cmp_low  : '0,
      cmp_en   : `RET_CTRL_RST,
      tick_div : TICK_DIV_RST,
      status   : '0,
      mask     : `RET_MASK_RST,
      match    : '0,
      rdata    : '0
   };

   ret_state_t st;
   ret_state_t next_st;

   logic       tick;
   ret_evt_t   match;
   ret_evt_t   clr;
   logic       wr_count;

   ret_time_if tif ();

   // ======================================================================
   // Tick divider.
   ret_tick_gen #(
      .DIV_W (`RET_DIV_W)
   ) u_tick (
      .clk_i  (MCLK_I),
      .rst_i  (RST_I),
      .div_i  (st.tick_div),
      .tick_o (tick)
   );

   // ======================================================================
   // Comparators: four on the full counter, one on its low 16 bits.
   assign tif.count = st.count;
   assign tif.upd   = st.upd;

   genvar gi;
   generate
      for (gi = 0; gi < `RET_NFULL; gi++)
      begin : g_full
         ret_comparator #(
            .W (`RET_CNT_W)
         ) u_cmp (
            .tif      (tif),
            .value_i  (st.cmp[gi]),
            .enable_i (st.cmp_en[gi]),
            .match_o  (match[gi])
         );
      end
   endgenerate

   ret_comparator #(
      .W (`RET_LOW_W)
   ) u_low_half_comparator (
      .tif      (tif),
      .value_i  (st.cmp_low),
      .enable_i (st.cmp_en[`RET_BIT_LOW]),
      .match_o  (match[`RET_BIT_LOW])
   );

   // ======================================================================
   // Read multiplexer; unmapped addresses read as zero.
   function automatic ret_word_t read_mux(input ret_state_t s, input ret_addr_t a);
      ret_word_t d;
      d = '0;
      case (a)
         `RET_OFF_CTRL:
            d[`RET_NEVT-1:0] = s.cmp_en;
         `RET_OFF_TICKDIV:
            d[`RET_DIV_W-1:0] = s.tick_div;
         `RET_OFF_COUNT:
            d[`RET_CNT_W-1:0] = s.count;
         `RET_OFF_CMP0:
            d[`RET_CNT_W-1:0] = s.cmp[0];
         `RET_OFF_CMP1:
            d[`RET_CNT_W-1:0] = s.cmp[1];
         `RET_OFF_CMP2:
            d[`RET_CNT_W-1:0] = s.cmp[2];
         `RET_OFF_CMP3:
            d[`RET_CNT_W-1:0] = s.cmp[3];
         `RET_OFF_CMPLOW:
            d[`RET_LOW_W-1:0] = s.cmp_low;
         `RET_OFF_STATUS:
            d[`RET_NEVT-1:0] = s.status;
         `RET_OFF_MASK:
            d[`RET_NEVT-1:0] = s.mask;
         default:
            d = '0;
      endcase
      return d;
   endfunction

   // ======================================================================
   // Write decode helpers.
   always_comb
   begin
      wr_count = WR_I && (ADDR_I == `RET_OFF_COUNT);
      clr      = '0;
      if (WR_I && (ADDR_I == `RET_OFF_STATUS))
      begin
         clr = WDATA_I[`RET_NEVT-1:0];
      end
   end

   // ======================================================================
   // Next state.
   always_comb
   begin
      next_st = st;

      // The counter never stops; a software load takes the place of a tick.
      next_st.upd = 1'b0;
      if (wr_count)
      begin
         next_st.count = WDATA_I[`RET_CNT_W-1:0];
         next_st.upd   = 1'b1;
      end
      else if (tick)
      begin
         next_st.count = st.count + 1'b1;
         next_st.upd   = 1'b1;
      end

      // Sticky flags: a match in the clearing cycle wins over the clear.
      next_st.status = (st.status & ~clr) | match;
      next_st.match  = match;

      // Configuration writes.
      if (WR_I)
      begin
         case (ADDR_I)
            `RET_OFF_CTRL:
               next_st.cmp_en = WDATA_I[`RET_NEVT-1:0];
            `RET_OFF_TICKDIV:
               next_st.tick_div = WDATA_I[`RET_DIV_W-1:0];
            `RET_OFF_CMP0:
               next_st.cmp[0] = WDATA_I[`RET_CNT_W-1:0];
            `RET_OFF_CMP1:
               next_st.cmp[1] = WDATA_I[`RET_CNT_W-1:0];
            `RET_OFF_CMP2:
               next_st.cmp[2] = WDATA_I[`RET_CNT_W-1:0];
            `RET_OFF_CMP3:
               next_st.cmp[3] = WDATA_I[`RET_CNT_W-1:0];
            `RET_OFF_CMPLOW:
               next_st.cmp_low = WDATA_I[`RET_LOW_W-1:0];
            `RET_OFF_MASK:
               next_st.mask = WDATA_I[`RET_NEVT-1:0];
            default:
               next_st.mask = st.mask;
         endcase
      end

      // Read data stand in the cycle after the strobe only.
      if (RD_I)
         next_st.rdata = read_mux(st, ADDR_I);
      else
         next_st.rdata = '0;
   end

   // ======================================================================
   // State register.
   always_ff @(posedge MCLK_I or posedge RST_I)
   begin
      if (RST_I)
         st <= RST_ST;
      else
         st <= next_st;
   end

   // ======================================================================
   // Outputs.
   assign RDATA_O     = st.rdata;
   assign IRQ_O       = |(st.status & st.mask);
   assign SEQ_COUNT_O = st.count;
   assign SEQ_MATCH_O = st.match;
   assign SEQ_TICK_O  = st.upd;
endmodule

// File: ret_timer_sva.sv
`include "ret_consts.svh"

module ret_timer_sva
(
   // Clock and reset.
   input wire logic               MCLK_I,
   input wire logic               RST_I,
   // Register port.
   input wire ret_pkg::ret_addr_t ADDR_I,
   input wire ret_pkg::ret_word_t WDATA_I,
   input wire logic               WR_I,
   input wire logic               RD_I,
   input wire ret_pkg::ret_word_t RDATA_O,
   // Events.
   input wire logic               IRQ_O,
   input wire ret_pkg::ret_cnt_t  SEQ_COUNT_O,
   input wire ret_pkg::ret_evt_t  SEQ_MATCH_O,
   input wire logic               SEQ_TICK_O
);
   timeunit 1ns;
   timeprecision 1ps;
   import ret_pkg::*;

   // ==========================================================================
   // Mask mirror, so that a match pulse can be tied to the interrupt.
   ret_evt_t mask_m;
   logic     cnt_wr;
   logic     cnt_rd;

   assign cnt_wr = WR_I && !RST_I && ADDR_I == `RET_OFF_COUNT;
   assign cnt_rd = RD_I && !RST_I && ADDR_I == `RET_OFF_COUNT;

   always_ff @(posedge MCLK_I or posedge RST_I)
      if (RST_I)
         mask_m <= `RET_MASK_RST;
      else if (WR_I && ADDR_I == `RET_OFF_MASK)
         mask_m <= WDATA_I[4:0];

   // ==========================================================================
   // Assertions.
   default clocking @(posedge MCLK_I); endclocking
   default disable iff (RST_I);

   count_tick_a: assert property (SEQ_COUNT_O != $past(SEQ_COUNT_O) |-> SEQ_TICK_O)
      else $error("count moved without tick");
   count_step_a: assert property (
      SEQ_TICK_O && !$past(cnt_wr) |-> SEQ_COUNT_O == $past(SEQ_COUNT_O) + 24'h1)
      else $error("count step wrong");
   count_load_a: assert property ($past(cnt_wr) |-> SEQ_TICK_O && SEQ_COUNT_O == $past(WDATA_I[23:0]))
      else $error("count load wrong");
   count_read_a: assert property ($past(cnt_rd) |-> RDATA_O == {8'h00, $past(SEQ_COUNT_O)})
      else $error("count read wrong");
   match_tick_a: assert property (SEQ_MATCH_O != 5'h00 |-> $past(SEQ_TICK_O))
      else $error("match without new count");
   match_irq_a: assert property ((SEQ_MATCH_O & mask_m) != 5'h00 |-> IRQ_O)
      else $error("enabled match without irq");
   irq_rise_a: assert property ($rose(IRQ_O) |-> $past(WR_I) || SEQ_MATCH_O != 5'h00)
      else $error("irq rose without cause");
   irq_hold_a: assert property ($fell(IRQ_O) |-> $past(WR_I))
      else $error("irq fell without write");
endmodule

bind ret_timer ret_timer_sva sva_i (.MCLK_I, .RST_I, .ADDR_I, .WDATA_I, .WR_I, .RD_I, .RDATA_O,
                                    .IRQ_O, .SEQ_COUNT_O, .SEQ_MATCH_O, .SEQ_TICK_O);

// File: tb.sv
`include "ret_consts.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ret_pkg::*;

   logic      mclk      = 1'b0;
   logic      rst       = 1'b1;
   ret_addr_t addr      = 8'h00;
   ret_word_t wdata     = 32'h0;
   logic      wr        = 1'b0;
   logic      rd        = 1'b0;
   ret_word_t rdata;
   logic      irq;
   ret_cnt_t  seq_count;
   logic      seq_tick;
   ret_cnt_t  b;
   ret_word_t exp_q[$];
   logic      rd_seen   = 1'b0;
   int        err_total = 0;
   int        checked   = 0;
   int        cycles    = 0;
   ret_cnt_t  r;
   int        i;
   int        k;

   always #12.5 mclk = ~mclk;

   ret_timer dut
   (
      .MCLK_I      (mclk),
      .RST_I       (rst),
      .ADDR_I      (addr),
      .WDATA_I     (wdata),
      .WR_I        (wr),
      .RD_I        (rd),
      .RDATA_O     (rdata),
      .IRQ_O       (irq),
      .SEQ_COUNT_O (seq_count),
      .SEQ_MATCH_O (),
      .SEQ_TICK_O  (seq_tick)
   );

   // ==========================================================================
   // Bus tasks and result checking.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         err_total++;
         $display("[FAIL] %0t ns: got %h, expected %h", $time, got, exp);
      end
   endtask

   task automatic wrr(input ret_addr_t a, input ret_word_t d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      rd <= 1'b0;
      @(posedge mclk);
   endtask

   task automatic rdr(input ret_addr_t a, input ret_word_t e);
      exp_q.push_back(e);
      addr <= a;
      wr <= 1'b0;
      rd <= 1'b1;
      @(posedge mclk);
   endtask

   task automatic idle(input int n);
      wr <= 1'b0;
      rd <= 1'b0;
      repeat (n) @(posedge mclk);
   endtask

   task automatic irq_is(input logic e, input ret_cnt_t c);
      @(negedge mclk);
      chk({31'h0, irq}, {31'h0, e});
      chk({8'h00, seq_count}, {8'h00, c});
      chk({31'h0, seq_tick}, 32'h1);
      @(posedge mclk);
   endtask

   task automatic give_verdict();
      if (err_total == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // Read data stands only in the cycle after the strobe.
   always @(posedge mclk)
   begin
      rd_seen <= rd;
      cycles <= cycles + 1;
      if (cycles == 3000)
      begin
         err_total++;
         give_verdict();
      end
   end

   always @(negedge mclk)
      if (rd_seen)
         chk(rdata, exp_q.pop_front());

   // ==========================================================================
   // Main sequence.
   initial
   begin
      void'($urandom(6));
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      for (i = 0; i <= 12; i++)
         rdr(8'(4 * i), (i == 1) ? `RET_TICK_DIV_RST : 32'h0);
      wrr(`RET_OFF_TICKDIV, 32'h0);
      rdr(`RET_OFF_TICKDIV, 32'h0);
      wrr(`RET_OFF_COUNT, 32'h00FFFFFE);
      rdr(`RET_OFF_COUNT, 32'h00FFFFFE);
      idle(3);
      rdr(`RET_OFF_COUNT, 32'h00000002);
      for (i = 0; i < 5; i++)
         for (k = 0; k < 3; k++)
         begin
            r = 24'($urandom) | 24'h000100;
            b = (i < 4) ? r : {~r[23:16], r[15:0]};
            wrr(`RET_OFF_CTRL, (k == 2) ? 32'h0 : 32'(1 << i));
            wrr(`RET_OFF_MASK, (k == 0) ? 32'(1 << i) : 32'h0);
            wrr((i < 4) ? 8'(`RET_OFF_CMP0 + 4 * i) : `RET_OFF_CMPLOW, {8'h00, r});
            wrr(`RET_OFF_COUNT, {8'h00, b - 24'h3});
            idle(8);
            irq_is(k == 0, b + 24'h5);
            rdr(`RET_OFF_STATUS, (k == 2) ? 32'h0 : 32'(1 << i));
            wrr(`RET_OFF_STATUS, 32'h1F);
            idle(1);
            irq_is(1'b0, b + 24'h9);
            rdr(`RET_OFF_STATUS, 32'h0);
         end
      idle(2);
      give_verdict();
   end
endmodule
